// ---- nco_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - add 20-bit increment, overflow divides frequency
// - fixed duty: toggle output on each overflow
// - pulse mode select clear means fixed duty
// - pulse mode: active for selected periods
// - pulse starts on edge after overflow
// - pulse mode select set means pulse
// - three-bit field selects pulse width
// - width beyond overflow spacing: no toggling
// - polarity applied last, sets active level
// - polarity change raises interrupt when enabled
// - overflow sets the interrupt flag
// - request needs all four enables set
// - flag stays set until software clears
// - reset clears every register to zero
// - runs from selected clock, not system clock
// - keep fast oscillator on when selected and the module is enabled
module nco_core #(
  parameter int ACC_W = nco_pkg::ACC_WIDTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic osc_module_enable,
  input wire logic pulse_mode_select,
  input wire logic output_polarity,
  input wire logic [2:0] pulse_width_select,
  input wire logic [ACC_W-1:0] increment_value,
  input wire logic fast_osc_selected,
  input wire logic overflow_irq_enable,
  input wire logic peripheral_irq_enable,
  input wire logic global_irq_enable,
  input wire logic overflow_irq_clear,
  output logic osc_output,
  output logic accum_overflow_event,
  output logic overflow_irq_flag,
  output logic overflow_irq_request,
  output logic fast_osc_keep_on,
  output logic [ACC_W-1:0] accum_value
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic ovf;
    logic toggle;
    logic [7:0] pulse_cnt;
    logic active;
    logic out;
    logic pol;
    logic flag;
  } nco_state_type;

  nco_state_type state_reg;
  nco_state_type state_next;

  // width in clock periods is a power of two, so a shift replaces a table
  function automatic logic [7:0] pulse_len(
    input logic [2:0] sel
  );
    pulse_len = nco_pkg::PULSE_ONE << sel;
  endfunction

  // one bit wider than the accumulator so the carry survives
  function automatic logic [ACC_W:0] acc_sum(
    input logic [ACC_W-1:0] acc,
    input logic [ACC_W-1:0] inc
  );
    acc_sum = {1'b0, acc} + {1'b0, inc};
  endfunction

  // interrupt chain: module, local, peripheral and global enables
  function automatic logic chain_enabled(
    input logic en,
    input logic local_en,
    input logic periph_en,
    input logic global_en
  );
    chain_enabled = en & local_en & periph_en & global_en;
  endfunction

  // polarity is the last stage, applied to either mode's raw level
  function automatic logic drive_level(
    input logic pulse_mode,
    input logic active,
    input logic toggle,
    input logic pol
  );
    drive_level = (pulse_mode ? active : toggle) ^ pol;
  endfunction

  // fixed duty engine: one toggle per registered overflow
  function automatic logic toggle_step(
    input logic ovf,
    input logic toggle
  );
    toggle_step = ovf ? ~toggle : toggle;
  endfunction

  // pulse engine, packed as {active, count}; an overflow always reloads,
  // so a width longer than the overflow spacing keeps the output active
  function automatic logic [8:0] pulse_step(
    input logic ovf,
    input logic active,
    input logic [7:0] cnt,
    input logic [7:0] reload
  );
    logic [8:0] result;
    result = {active, cnt};
    if (ovf)
    begin
      result = {1'b1, reload};
    end
    else if (active && (cnt == 8'h00))
    begin
      result = {1'b0, cnt};
    end
    else if (active)
    begin
      result = {1'b1, cnt - 8'h01};
    end
    pulse_step = result;
  endfunction

  // a set in the same cycle as a software clear wins, so no event is lost
  function automatic logic flag_update(
    input logic flag,
    input logic clr,
    input logic set
  );
    logic result;
    result = flag;
    if (flag && clr)
    begin
      result = 1'b0;
    end
    if (set)
    begin
      result = 1'b1;
    end
    flag_update = result;
  endfunction

  logic [ACC_W:0] sum;
  logic carry;
  logic pin_level;
  logic all_en;
  logic pol_changed;
  logic flag_set;
  logic [7:0] width_cnt;
  logic [8:0] pulse_pair;

  always_comb
  begin
    state_next = state_reg;
    sum = acc_sum(state_reg.acc, increment_value);
    // no overflow is reported while disabled, even if the sum would wrap
    carry = osc_module_enable & sum[ACC_W];
    all_en = chain_enabled(osc_module_enable, overflow_irq_enable,
      peripheral_irq_enable, global_irq_enable);
    pol_changed = output_polarity ^ state_reg.pol;
    width_cnt = pulse_len(pulse_width_select) - 8'h01;
    pulse_pair = pulse_step(state_reg.ovf, state_reg.active,
      state_reg.pulse_cnt, width_cnt);
    flag_set = carry | (all_en & pol_changed);

    // accumulator and registered overflow event
    state_next.ovf = carry;
    state_next.pol = output_polarity;
    if (osc_module_enable)
    begin
      state_next.acc = sum[ACC_W-1:0];
    end
    else
    begin
      state_next.acc = state_reg.acc;
    end
    // overflow pulse is registered, so pulse output rises one edge later
    if (!osc_module_enable)
    begin
      state_next.toggle = 1'b0;
      state_next.active = 1'b0;
      state_next.pulse_cnt = 8'h00;
    end
    else if (!pulse_mode_select)
    begin
      state_next.active = 1'b0;
      state_next.pulse_cnt = 8'h00;
      state_next.toggle = toggle_step(state_reg.ovf, state_reg.toggle);
    end
    else
    begin
      state_next.toggle = 1'b0;
      // registered overflow, so the pulse starts on the following edge
      state_next.active = pulse_pair[8];
      state_next.pulse_cnt = pulse_pair[7:0];
    end
    // output stage
    pin_level = drive_level(pulse_mode_select, state_next.active,
      state_next.toggle, output_polarity);
    state_next.out = pin_level;

    // interrupt flag; a polarity change only counts with the chain enabled
    state_next.flag = flag_update(state_reg.flag, overflow_irq_clear,
      flag_set);
    if (sys_rst)
    begin
      state_next = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    state_reg <= state_next;
  end

  assign osc_output = state_reg.out;
  assign accum_overflow_event = state_reg.ovf;
  assign overflow_irq_flag = state_reg.flag;
  assign overflow_irq_request = state_reg.flag
    & chain_enabled(osc_module_enable, overflow_irq_enable,
    peripheral_irq_enable, global_irq_enable);
  assign fast_osc_keep_on = osc_module_enable & fast_osc_selected;
  assign accum_value = state_reg.acc;

endmodule
`default_nettype wire

// ---- nco_pkg.sv ----
package nco_pkg;
  localparam int ACC_WIDTH = 20;
  localparam int PWS_WIDTH = 3;
  localparam logic [19:0] ACC_RESET = 20'h00000;
  localparam logic [19:0] INC_RESET = 20'h00000;
  localparam logic [2:0] PWS_RESET = 3'h0;
  // pulse width in clock periods is 2 to the power of the select field
  localparam logic [7:0] PULSE_ONE = 8'h01;
endpackage

// ---- nco_core_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module nco_core_monitor(input wire logic clk,sys_rst,osc_module_enable,
pulse_mode_select,output_polarity,overflow_irq_enable,peripheral_irq_enable,
global_irq_enable,overflow_irq_clear,osc_output,accum_overflow_event,
overflow_irq_flag,overflow_irq_request,
input wire logic [19:0] increment_value,accum_value);
wire e=osc_module_enable,o=osc_output,v=accum_overflow_event,
f=overflow_irq_flag,p=output_polarity,m=pulse_mode_select;
wire [20:0] s={1'h0,accum_value}+increment_value;
wire c=e&s[20];
default clocking @(posedge clk);endclocking
default disable iff(sys_rst);
AST_SUM:
assert property(e|=>accum_value==$past(accum_value)+$past(increment_value))
else $error("sum");
AST_HOLD:
assert property(!e|=>$stable(accum_value)&&!v&&o==$past(p)) else $error("hold");
AST_CARRY:
assert property(!$past(sys_rst)|->v==$past(c)) else $error("carry");
AST_STICKY:
assert property(f&&!overflow_irq_clear|=>f) else $error("sticky");
AST_REQ:
assert property(overflow_irq_request==(f&e&overflow_irq_enable&
peripheral_irq_enable&global_irq_enable)) else $error("req");
AST_FDC:
assert property(v&&e&&!m&&$stable(p)&&$stable(m)|=>$changed(o))
else $error("fdc");
AST_PF:
assert property(v&&e&&m&&$stable(p)&&o==p|=>o!=$past(p)) else $error("pf");
AST_RST:
assert property(disable iff(1'h0) sys_rst|=>!accum_value&&!f&&!o&&!v)
else $error("rst");
cover property(v&&m);
cover property(overflow_irq_request);
cover property(f&&overflow_irq_clear);
cover property(e&&m&&v&&o!=p);
endmodule
bind nco_core nco_core_monitor mon(.*);
`default_nettype wire

// ---- numeric_osc_accumulator_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module numeric_osc_accumulator_test;
logic clk=0,sys_rst=1,osc_module_enable=0,pulse_mode_select=0,
output_polarity=0,fast_osc_selected=0,overflow_irq_enable=0,
peripheral_irq_enable=0,global_irq_enable=0,overflow_irq_clear=0,
osc_output,accum_overflow_event,overflow_irq_flag,overflow_irq_request,
fast_osc_keep_on;
logic [2:0] pulse_width_select=0;
logic [19:0] increment_value=0,accum_value;
// fast inc, pulse, polarity, width; high cycles in any 512 window
logic [15:0] rows[11]='{16'h4002,16'h4404,16'h4808,16'h4C10,16'h5020,
16'h5440,16'h5880,16'h5D00,16'h0100,16'h6DF0,16'hDE00};
int fails=0,checks=0,cyc=0,n;
nco_core uut(.*);
initial forever #5 clk=~clk;
always @(posedge clk) if(++cyc==20000) begin fails++; final_report; end
task go(int k); repeat(k) @(posedge clk); endtask
task chk(logic [22:0] g,x); checks++;
if(g!==x) begin fails++; $display("BAD %0t got %h",$time,g); end endtask
task final_report; $display("checks %0d fails %0d",checks,fails);
if(fails==0&&checks>0) $display("Result: passed");
else $display("Result: failed");
$finish; endtask
initial begin
go(6); sys_rst<=1'h0; osc_module_enable<=1'h1;
foreach(rows[i]) begin
{pulse_mode_select,output_polarity,pulse_width_select}<=rows[i][14:10];
increment_value<=rows[i][15]?20'h80000:20'h01000;
go(600); n=0;
// sample mid-cycle, where the registered output has settled
repeat(512) begin @(negedge clk); n+=osc_output; end
go(1);
chk(n,rows[i][9:0]);
$display("row %0d done",i); end
{overflow_irq_enable,peripheral_irq_enable,global_irq_enable,
fast_osc_selected}<=4'hF; go(2);
chk({overflow_irq_request,fast_osc_keep_on},2'h3);
osc_module_enable<=1'h0; output_polarity<=1'h1; go(3);
chk({osc_output,overflow_irq_request,fast_osc_keep_on},3'h4);
overflow_irq_clear<=1'h1; go(1); overflow_irq_clear<=1'h0; go(2);
chk(overflow_irq_flag,1'h0);
osc_module_enable<=1'h1; increment_value<=20'h0; go(2);
output_polarity<=1'h0; go(2);
chk(overflow_irq_flag,1'h1);
sys_rst<=1'h1; go(1); sys_rst<=1'h0; @(negedge clk);
chk({accum_value,overflow_irq_flag,accum_overflow_event,osc_output},23'h0);
$display("control tests done"); final_report; end
endmodule
`default_nettype wire
